// ---- inc/xms_pkg.sv ----
// constants, register map and state type for the external data bus and stack map block
// ============================================================================
package xms_pkg;

	// ========================================================================
	// register indices, byte address is four times the index
	localparam logic [7:0]  IDX_SP       = 8'h81;
	localparam logic [7:0]  IDX_SPX      = 8'h9E;
	localparam logic [7:0]  IDX_AUX      = 8'h8E;
	localparam logic [7:0]  IDX_STAT     = 8'hA0;
	localparam logic [7:0]  IDX_RDAT     = 8'hA1;
	localparam logic [11:0] ADR_SP       = {2'h0, IDX_SP, 2'h0};
	localparam logic [11:0] ADR_SPX      = {2'h0, IDX_SPX, 2'h0};
	localparam logic [11:0] ADR_AUX      = {2'h0, IDX_AUX, 2'h0};
	localparam logic [11:0] ADR_STAT     = {2'h0, IDX_STAT, 2'h0};
	localparam logic [11:0] ADR_RDAT     = {2'h0, IDX_RDAT, 2'h0};

	// ========================================================================
	// reset values
	localparam logic [7:0]  SP_RST       = 8'h07;
	localparam logic [3:0]  SPX_RST      = 4'h0;
	localparam logic [4:0]  AUX_RST      = 5'h00;

	// ========================================================================
	// field positions
	localparam int          AUX_STACK_EXTEND_SELECT     = 4;
	localparam int          AUX_WS_HI    = 3;
	localparam int          AUX_WS_LO    = 2;
	localparam int          AUX_EXTERNAL_ONLY_MAP    = 1;
	localparam int          AUX_LATCH_IDLE_LOW     = 0;
	localparam int          STAT_BUSY    = 0;
	localparam int          STAT_EXT     = 1;
	localparam int          STAT_STALL   = 2;

	// ========================================================================
	// sizes and timing counts
	localparam logic [16:0] INT_MAP_SIZE = 17'h01000;
	localparam int          SYNC_STAGES  = 2;
	localparam logic [1:0]  SETTLE_CNT   = 2'(SYNC_STAGES - 1);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_LATCH,
		ST_STROBE,
		ST_SETTLE,
		ST_DONE
	} xms_state_e;

endpackage : xms_pkg

// ---- inc/xms_stk_if.sv ----
// stack address signals shared between the top and the stack address former
`timescale 1ns/1ps
interface xms_stk_if;
	logic [7:0]  sp;
	logic [3:0]  stack_upper_nibble;
	logic        ext;
	logic [11:0] addr;
	logic        extra;
	modport calc (input sp, input stack_upper_nibble, input ext, output addr, output extra);
	modport user (output sp, output stack_upper_nibble, output ext, input addr, input extra);
endinterface : xms_stk_if

// ---- rtl/xms_stack_addr.sv ----
// stack address former for the direct and the extended stack
`timescale 1ns/1ps
module xms_stack_addr
	import xms_pkg::*;
(
	xms_stk_if.calc s
);
	// extension nibble only counts in extended mode
	always_comb begin
		s.addr  = s.ext ? {s.stack_upper_nibble, s.sp} : {4'h0, s.sp};
		s.extra = s.ext;
	end
endmodule : xms_stack_addr

// ---- rtl/xms_wait_timer.sv ----
// small loadable down counter used for strobe stretch, settle and stack stall
`timescale 1ns/1ps
module xms_wait_timer
	import xms_pkg::*;
#(
	parameter int W = 2
)(
	input  wire logic         CLK,
	input  wire logic         RSTN,
	input  wire logic         LOAD,
	input  wire logic [W-1:0] VAL,
	output logic              ZERO,
	output logic              BUSY
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	// load wins, otherwise count down to zero and stop
	always_comb begin
		cnt_next = cnt_reg;
		if (LOAD) begin
			cnt_next = VAL;
		end else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - W'(1);
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			cnt_reg <= '0;
			BUSY    <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			BUSY    <= (cnt_next != '0);
		end
	end

	assign ZERO = (cnt_reg == '0);
endmodule : xms_wait_timer

// ---- rtl/xms_top.sv ----
// external data bus sequencer, data space map and stack address logic with APB registers
`timescale 1ns/1ps
module xms_top
	import xms_pkg::*;
#(
	parameter logic [16:0] INT_SIZE = INT_MAP_SIZE
)(
	input  wire logic        CLK,
	input  wire logic        RSTN,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// core data access request
	input  wire logic        XREQ,
	input  wire logic        XWRITE,
	input  wire logic        XPAGED,
	input  wire logic [15:0] XADDR,
	input  wire logic [7:0]  XWDATA,
	output logic             XBUSY,
	output logic             XDONE,
	output logic      [7:0]  XRDATA,
	output logic             XINT_SEL,
	output logic      [15:0] XINT_ADDR,
	// core stack side
	input  wire logic        STK_INC,
	input  wire logic        STK_DEC,
	input  wire logic        STK_OP,
	input  wire logic [1:0]  STK_NACC,
	output logic      [11:0] STK_ADDR,
	output logic             STK_EXTRA,
	output logic             STK_STALL,
	// low-byte port idle configuration
	input  wire logic [7:0]  P0_IDLE_DO,
	input  wire logic [7:0]  P0_IDLE_OEN,
	// pins
	input  wire logic [7:0]  P0_DI,
	output logic      [7:0]  P0_DO,
	output logic      [7:0]  P0_OEN,
	output logic      [7:0]  P2_DO,
	output logic             P2_OWN,
	output logic             ALE_O,
	output logic             RD_N,
	output logic             WR_N
);
	// ========================================================================
	// registers
	logic [7:0]  sp_reg;
	logic [3:0]  spx_reg;
	logic [4:0]  aux_reg;
	logic        stack_extend_select, external_only_map, latch_idle_low;
	logic [1:0]  ws;
	logic        wr_hit, rd_hit;

	assign stack_extend_select  = aux_reg[AUX_STACK_EXTEND_SELECT];
	assign ws    = aux_reg[AUX_WS_HI:AUX_WS_LO];
	assign external_only_map = aux_reg[AUX_EXTERNAL_ONLY_MAP];
	assign latch_idle_low  = aux_reg[AUX_LATCH_IDLE_LOW];

	// write commits only at the access edge with ready high
	assign wr_hit = PSEL && PENABLE && PREADY && PWRITE;
	assign rd_hit = PSEL && !PENABLE;

	// apb: one wait-free access phase, ready answered from a flop
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0000_0000;
		end else begin
			PREADY  <= rd_hit;
			PSLVERR <= 1'b0;
			if (rd_hit) begin
				PRDATA <= 32'h0000_0000;
				unique case (PADDR)
					ADR_SP:   PRDATA[7:0] <= sp_reg;
					ADR_SPX:  PRDATA[3:0] <= spx_reg;
					ADR_AUX:  PRDATA[4:0] <= aux_reg;
					ADR_STAT: PRDATA[2:0] <= {STK_STALL, P2_OWN | XBUSY, XBUSY};
					ADR_RDAT: PRDATA[7:0] <= XRDATA;
					default:  PSLVERR     <= 1'b1; // unmapped word
				endcase
			end
		end
	end

	// auxiliary control, software only
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			aux_reg <= AUX_RST;
		end else if (wr_hit && PADDR == ADR_AUX) begin
			aux_reg <= PWDATA[4:0];
		end
	end

	// ========================================================================
	// stack pointer pair; software write beats a core step in the same cycle
	logic [8:0] sp_up, sp_dn;
	assign sp_up = {1'b0, sp_reg} + 9'h001;
	assign sp_dn = {1'b0, sp_reg} - 9'h001;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sp_reg  <= SP_RST;
			spx_reg <= SPX_RST;
		end else begin
			if (wr_hit && PADDR == ADR_SP) begin
				sp_reg <= PWDATA[7:0];
			end else if (STK_INC) begin
				sp_reg <= sp_up[7:0];
				// carry only within the extended stack
				if (stack_extend_select && sp_up[8]) spx_reg <= spx_reg + 4'h1;
			end else if (STK_DEC) begin
				sp_reg <= sp_dn[7:0];
				if (stack_extend_select && sp_dn[8]) spx_reg <= spx_reg - 4'h1;
			end
			if (wr_hit && PADDR == ADR_SPX) begin
				spx_reg <= PWDATA[3:0];
			end
		end
	end

	xms_stk_if stk ();
	assign stk.sp  = sp_reg;
	assign stk.stack_upper_nibble = spx_reg;
	assign stk.ext = stack_extend_select;

	xms_stack_addr u_stack (
		.s (stk.calc)
	);

	// stack address registered; never routed to the external bus
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			STK_ADDR  <= 12'h000;
			STK_EXTRA <= 1'b0;
		end else begin
			STK_ADDR  <= stk.addr;
			STK_EXTRA <= stk.extra;
		end
	end

	// extended stack stall, one cycle per stack access
	xms_wait_timer #(.W(2)) u_stall (
		.CLK  (CLK),
		.RSTN (RSTN),
		.LOAD (STK_OP && stack_extend_select),
		.VAL  (STK_NACC),
		.ZERO (),
		.BUSY (STK_STALL)
	);

	// ========================================================================
	// read data synchroniser
	logic [7:0] p0_s1, p0_s2;
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			p0_s1 <= 8'h00;
			p0_s2 <= 8'h00;
		end else begin
			p0_s1 <= P0_DI;
			p0_s2 <= p0_s1;
		end
	end

	// ========================================================================
	// bus sequencer
	xms_state_e st_reg, st_next;
	logic       go_int, go_ext, tmr_load, tmr_zero;
	logic [1:0] tmr_val;
	logic       wr_l, pg_l;
	logic [15:0] addr_l;
	logic [7:0]  wd_l;

	// map decision: internal window only when the external-only bit is clear
	always_comb begin
		go_ext = 1'b0;
		go_int = 1'b0;
		if (st_reg == ST_IDLE && XREQ) begin
			if (external_only_map || {1'b0, XADDR} >= INT_SIZE) go_ext = 1'b1;
			else go_int = 1'b1;
		end
	end

	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			ST_IDLE:   if (go_ext) st_next = ST_ADDR;
			ST_ADDR:   st_next = ST_LATCH;
			ST_LATCH:  st_next = ST_STROBE;
			ST_STROBE: if (tmr_zero) st_next = wr_l ? ST_DONE : ST_SETTLE;
			ST_SETTLE: if (tmr_zero) st_next = ST_DONE;
			ST_DONE:   st_next = ST_IDLE;
		endcase
	end

	// timer loaded with wait count on strobe entry, settle count after a read
	always_comb begin
		tmr_load = 1'b0;
		tmr_val  = ws;
		if (st_reg == ST_LATCH) begin
			tmr_load = 1'b1;
		end else if (st_reg == ST_STROBE && st_next == ST_SETTLE) begin
			tmr_load = 1'b1;
			tmr_val  = SETTLE_CNT;
		end
	end

	xms_wait_timer #(.W(2)) u_wait (
		.CLK  (CLK),
		.RSTN (RSTN),
		.LOAD (tmr_load),
		.VAL  (tmr_val),
		.ZERO (tmr_zero),
		.BUSY ()
	);

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) st_reg <= ST_IDLE;
		else       st_reg <= st_next;
	end

	// request captured once, held until the strobe has ended
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			wr_l   <= 1'b0;
			pg_l   <= 1'b0;
			addr_l <= 16'h0000;
			wd_l   <= 8'h00;
		end else if (go_ext) begin
			wr_l   <= XWRITE;
			pg_l   <= XPAGED;
			addr_l <= XADDR;
			wd_l   <= XWDATA;
		end
	end

	// core handshake; internal accesses finish in one cycle
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			XBUSY     <= 1'b0;
			XDONE     <= 1'b0;
			XRDATA    <= 8'h00;
			XINT_SEL  <= 1'b0;
			XINT_ADDR <= 16'h0000;
		end else begin
			XBUSY    <= (st_next != ST_IDLE);
			XDONE    <= go_int || st_next == ST_DONE;
			XINT_SEL <= go_int;
			if (go_int) XINT_ADDR <= XADDR;
			// value from the last strobe cycle has crossed both stages here
			if (st_reg == ST_SETTLE && tmr_zero) XRDATA <= p0_s2;
		end
	end

	// pins driven from the coming state so they all leave flops together
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ALE_O  <= 1'b1;
			RD_N   <= 1'b1;
			WR_N   <= 1'b1;
			P0_DO  <= 8'h00;
			P0_OEN <= 8'hFF;
			P2_DO  <= 8'h00;
			P2_OWN <= 1'b0;
		end else begin
			unique case (st_next)
				ST_IDLE: begin
					ALE_O  <= !latch_idle_low;
					RD_N   <= 1'b1;
					WR_N   <= 1'b1;
					P0_DO  <= P0_IDLE_DO;
					P0_OEN <= P0_IDLE_OEN;
					P2_OWN <= 1'b0;
				end
				ST_ADDR: begin
					ALE_O  <= 1'b1;
					P0_DO  <= XADDR[7:0];
					P0_OEN <= 8'h00;
					P2_DO  <= XADDR[15:8];
					P2_OWN <= !XPAGED;
				end
				ST_LATCH: begin
					ALE_O  <= 1'b0;
				end
				ST_STROBE: begin
					RD_N   <= wr_l;
					WR_N   <= !wr_l;
					P0_DO  <= wd_l;
					P0_OEN <= wr_l ? 8'h00 : 8'hFF;
				end
				default: begin
					ALE_O  <= 1'b0;
					RD_N   <= 1'b1;
					WR_N   <= 1'b1;
					P0_OEN <= wr_l ? 8'h00 : 8'hFF;
				end
			endcase
		end
	end

	// ========================================================================
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	logic [2:0] strb_len;
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) strb_len <= 3'h0;
		else if (!RD_N || !WR_N) strb_len <= strb_len + 3'h1;
		else strb_len <= 3'h0;
	end

	ale_idle_a: assert property (
		(st_reg == ST_IDLE) && $past(st_reg == ST_IDLE) && $stable(latch_idle_low) |-> ALE_O == !latch_idle_low)
		else $error("latch strobe not at idle level");
	ale_pulse_a: assert property (
		go_ext |=> ALE_O ##1 !ALE_O [*2] ##0 (!RD_N || !WR_N))
		else $error("latch pulse missing before strobe");
	addr_hold_a: assert property (
		st_reg == ST_LATCH |-> $stable(P0_DO) && $stable(P2_DO) && P0_OEN == 8'h00)
		else $error("address moved at latch fall");
	strobe_len_a: assert property (
		(strb_len != 3'h0) && RD_N && WR_N |-> strb_len == {1'b0, ws} + 3'h1)
		else $error("strobe width differs from wait count");
	p0_dir_a: assert property (
		(!RD_N |-> P0_OEN == 8'hFF) and (!WR_N |-> P0_OEN == 8'h00 && P0_DO == wd_l))
		else $error("low-byte port direction wrong");
	p0_idle_a: assert property (
		$past(RSTN) && st_reg == ST_IDLE && $past(st_reg == ST_IDLE)
		|-> P0_OEN == $past(P0_IDLE_OEN))
		else $error("low-byte port not at idle setting");
	map_route_a: assert property (
		XREQ && st_reg == ST_IDLE && !external_only_map && {1'b0, XADDR} < INT_SIZE
		|=> XINT_SEL && XDONE && st_reg == ST_IDLE)
		else $error("internal address left the chip");
	stk_direct_a: assert property (
		!stack_extend_select && $stable(stack_extend_select) |=> STK_ADDR[11:8] == 4'h0 && !STK_EXTRA)
		else $error("direct stack reached extra RAM");
	stall_two_a: assert property (
		STK_OP && stack_extend_select && STK_NACC == 2'h2 |=> STK_STALL [*2] ##1 !STK_STALL)
		else $error("extended stack stall length wrong");
	paged_a: assert property (
		st_reg == ST_ADDR |-> P2_OWN == !pg_l)
		else $error("high port ownership wrong for mode");

endmodule : xms_top

// ---- dv/xms_ram_model.sv ----
// external byte RAM behind an address latch, seen from the bus pins
`timescale 1ns/1ps
module xms_ram_model (
	input  wire logic       CLK,
	input  wire logic       ALE_O,
	input  wire logic       RD_N,
	input  wire logic       WR_N,
	input  wire logic [7:0] P0,
	input  wire logic [7:0] P2_DO,
	input  wire logic       P2_OWN,
	output logic      [7:0] Q
);
	logic [7:0]  mem [0:65535];
	logic [7:0]  lo_reg;
	logic [7:0]  last_reg;
	logic [15:0] adr;

	// ========================================================================
	// latch and array
	// paged cycles leave the high byte to port pins, taken here as zero
	assign adr = {P2_OWN ? P2_DO : 8'h00, lo_reg};
	// latch is transparent while the strobe is high, so it keeps the last value
	always @(posedge CLK) begin
		if (ALE_O) lo_reg <= P0;
		if (!WR_N) mem[adr] <= P0;
		if (!RD_N) last_reg <= mem[adr];
	end
	// released bus shows the inverse of the last byte, never a stale match
	assign Q = RD_N ? ~last_reg : mem[adr];
endmodule : xms_ram_model

// ---- dv/tb.sv ----
// self-checking bench for the external bus, data map and stack logic
`timescale 1ns/1ps
module tb;
	import xms_pkg::*;
	logic CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, XREQ = 0, XWRITE = 0;
	logic XPAGED = 0, STK_INC = 0, STK_DEC = 0, STK_OP = 0, latch_idle_low = 0;
	logic [11:0] PADDR = 0;
	logic [31:0] PWDATA = 0, PRDATA;
	logic [15:0] XADDR = 0, XINT_ADDR;
	logic [7:0]  XWDATA = 0, XRDATA, P0_DI, P0_DO, P0_OEN, P2_DO, ram_q;
	logic [7:0]  P0_IDLE_DO = 8'h3C, P0_IDLE_OEN = 8'hA5;
	logic [1:0]  STK_NACC = 0;
	logic [11:0] STK_ADDR;
	logic PREADY, PSLVERR, XBUSY, XDONE, XINT_SEL, STK_EXTRA, STK_STALL, P2_OWN, ALE_O, RD_N, WR_N;
	int bad_count = 0, n_tests = 0, cyc = 0;

	// ========================================================================
	// clock, pin wiring, design and far side
	always #10 CLK = ~CLK;
	assign P0_DI = (~P0_OEN & P0_DO) | (P0_OEN & ram_q);
	xms_top i_dut (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.XREQ(XREQ), .XWRITE(XWRITE), .XPAGED(XPAGED), .XADDR(XADDR), .XWDATA(XWDATA),
		.XBUSY(XBUSY), .XDONE(XDONE), .XRDATA(XRDATA), .XINT_SEL(XINT_SEL),
		.XINT_ADDR(XINT_ADDR), .STK_INC(STK_INC), .STK_DEC(STK_DEC), .STK_OP(STK_OP),
		.STK_NACC(STK_NACC), .STK_ADDR(STK_ADDR), .STK_EXTRA(STK_EXTRA), .STK_STALL(STK_STALL),
		.P0_IDLE_DO(P0_IDLE_DO), .P0_IDLE_OEN(P0_IDLE_OEN), .P0_DI(P0_DI), .P0_DO(P0_DO),
		.P0_OEN(P0_OEN), .P2_DO(P2_DO), .P2_OWN(P2_OWN), .ALE_O(ALE_O), .RD_N(RD_N), .WR_N(WR_N));
	// strobes and high port reach the far side only as driven outputs
	xms_ram_model i_ram (.CLK(CLK), .ALE_O(ALE_O), .RD_N(RD_N), .WR_N(WR_N), .P0(P0_DI),
		.P2_DO(P2_DO), .P2_OWN(P2_OWN), .Q(ram_q));

	// ========================================================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge CLK);
		PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= a; PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1;
		// ready judged at the rising edge; only the watchdog ends a hang
		do begin
			@(posedge CLK);
		end while (PREADY !== 1'b1);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 0; PENABLE <= 0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r; logic e;
		apb(1, a, d, r, e);
	endtask : wr
	task automatic rdc(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] r; logic e;
		apb(0, a, 0, r, e);
		chk(r, x, "reg read");
	endtask : rdc
	// one core access, watching latch, strobes and port direction
	task automatic xacc(input logic w, pg, input logic [15:0] a, input logic [7:0] d,
		input int ws, input logic ext, output logic [7:0] r);
		int n, sl, fal; logic pa, isel;
		n = 0; sl = 0; fal = 0; isel = 0; pa = ALE_O;
		@(posedge CLK);
		XREQ <= 1; XWRITE <= w; XPAGED <= pg; XADDR <= a; XWDATA <= d;
		@(posedge CLK);
		XREQ <= 0;
		do begin
			@(negedge CLK); n++;
			chk(XBUSY, ext, "busy level");
			if (pa && !ALE_O) begin
				fal++;
				chk(P0_DO, a[7:0], "addr lo at latch fall");
				if (!pg) chk(P2_DO, a[15:8], "addr hi at latch fall");
			end
			pa = ALE_O;
			if (!WR_N || !RD_N) begin
				sl++;
				chk(P0_OEN, w ? 8'h00 : 8'hFF, "low port direction");
				chk(P2_OWN, !pg, "high port owner");
				if (!WR_N) chk(P0_DO, d, "write data");
			end
			if (XINT_SEL === 1'b1) begin isel = 1; chk(XINT_ADDR, a, "internal addr"); end
		end while (XDONE !== 1'b1 && n < 40);
		r = XRDATA;
		chk(32'(n < 40), 1, "access done");
		chk(32'(fal), 32'(ext), "latch pulses");
		chk(isel, !ext, "routing");
		if (ext) chk(32'(sl), 32'(ws + 1), "strobe width");
		@(negedge CLK);
		@(negedge CLK);
		chk(P0_OEN, P0_IDLE_OEN, "idle direction");
		chk(P0_DO, P0_IDLE_DO, "idle data");
		chk(ALE_O, !latch_idle_low, "latch idle");
		chk(XBUSY, 0, "busy released");
	endtask : xacc
	task automatic step(input logic up);
		@(posedge CLK); STK_INC <= up; STK_DEC <= !up;
		@(posedge CLK); STK_INC <= 0; STK_DEC <= 0;
		repeat (2) @(negedge CLK);
	endtask : step
	task automatic opc(input logic [1:0] k, input int x);
		int c;
		c = 0;
		@(posedge CLK); STK_OP <= 1; STK_NACC <= k;
		@(posedge CLK); STK_OP <= 0;
		repeat (5) begin @(negedge CLK); c += int'(STK_STALL === 1'b1); end
		chk(32'(c), 32'(x), "stall cycles");
	endtask : opc

	// ========================================================================
	// scenarios
	task automatic t_regs();
		logic [31:0] r; logic e;
		rdc(ADR_SP, 32'h07);
		rdc(ADR_SPX, 32'h0);
		rdc(ADR_AUX, 32'h0);
		wr(ADR_AUX, 32'hFFFFFFFF);
		rdc(ADR_AUX, 32'h1F);
		apb(0, 12'hFFC, 0, r, e);
		chk({r[30:0], e}, 32'h1, "unmapped read");
		apb(1, 12'hFFC, 32'hFFFFFFFF, r, e);
		chk(e, 1, "unmapped write");
		rdc(ADR_AUX, 32'h1F);
		$display("test regs done");
	endtask : t_regs
	task automatic t_bus();
		logic [7:0] r;
		for (int l = 0; l < 2; l++) begin
			for (int ws = 0; ws < 4; ws++) begin
				latch_idle_low = l[0];
				wr(ADR_AUX, 32'(ws * 4 + 2 + l));
				xacc(1, 0, 16'h8000 + 16'(ws), 8'h5A ^ 8'(ws), ws, 1, r);
				xacc(0, 0, 16'h8000 + 16'(ws), 8'h00, ws, 1, r);
				chk(r, 8'h5A ^ 8'(ws), "read back");
			end
			xacc(1, 1, 16'h0042, 8'hC3, 3, 1, r);
			xacc(0, 1, 16'h0042, 8'h00, 3, 1, r);
			chk(r, 8'hC3, "paged read back");
		end
		rdc(ADR_RDAT, 32'h0C3);
		$display("test bus done");
	endtask : t_bus
	task automatic t_map();
		logic [7:0] r;
		latch_idle_low = 0;
		P0_IDLE_OEN <= 8'h5A;
		wr(ADR_AUX, 32'h0);
		xacc(0, 0, 16'h0123, 8'h00, 0, 0, r);
		xacc(1, 0, 16'h0FFF, 8'h11, 0, 0, r);
		xacc(1, 0, 16'h1000, 8'h22, 0, 1, r);
		xacc(1, 1, 16'h0077, 8'h33, 0, 0, r);
		$display("test map done");
	endtask : t_map
	task automatic t_stack();
		wr(ADR_SP, 32'hFF);
		wr(ADR_SPX, 32'h5);
		step(1);
		chk(STK_ADDR, 12'h000, "direct wrap");
		chk(STK_EXTRA, 0, "direct ram");
		rdc(ADR_SPX, 32'h5);
		opc(2, 0);
		wr(ADR_AUX, 32'h12);
		wr(ADR_SP, 32'hFF);
		wr(ADR_SPX, 32'h3);
		step(1);
		chk(STK_ADDR, 12'h400, "extended carry");
		chk(STK_EXTRA, 1, "extra ram");
		step(0);
		chk(STK_ADDR, 12'h3FF, "extended borrow");
		opc(2, 2);
		opc(1, 1);
		rdc(ADR_STAT, 32'h0);
		$display("test stack done");
	endtask : t_stack

	// ========================================================================
	// main sequence and hang guard
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			wrap_up();
		end
	end
	initial begin
		repeat (12) @(posedge CLK);
		RSTN <= 1;
		@(negedge CLK);
		chk(ALE_O, 1, "latch idle after reset");
		t_regs();
		t_bus();
		t_map();
		t_stack();
		wrap_up();
	end
endmodule : tb
